// ---- verilog/por_wake_pkg.sv ----
// Package: constants and carrier types for the reset and idle wake-up block
package por_wake_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned BANDGAP_SETTLE_MS = 8;
    localparam int unsigned ANALOG_SETTLE_MS  = 4;
    localparam int unsigned BANDGAP_CYCLES    = BANDGAP_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned ANALOG_CYCLES     = ANALOG_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned RTC_PERIOD_NS     = 30500;
    localparam int unsigned RTC_WAKE_CYCLES   = (RTC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REF_WAKE_CYCLES   = 1;
    localparam int unsigned LIGHT_WAKE_CYCLES = 3;
    localparam int unsigned RESET_MIN_CYCLES  = 3;

    // ------------------------------------------------------------------
    // Pin reset levels
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W   = 21;
    localparam int unsigned CS_W     = 4;
    localparam logic [1:0]  BANK_RST = 2'h3;
    localparam logic [20:0] ADDR_RST = 21'h000000;

    // Power states
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_RUN   = 2'b01,
        ST_LIGHT = 2'b10,
        ST_DEEP  = 2'b11
    } power_state_t;

    // Memory-side pin group driven during reset
    typedef struct packed {
        logic [CS_W-1:0]   chipSelectN;
        logic              outputEnableN;
        logic              writeEnableN;
        logic [1:0]        byteMaskN;
        logic              readWrite;
        logic [ADDR_W-1:0] address;
        logic [1:0]        bankAddress;
    } mem_pins_t;

    // Serial/display and misc pin group driven during reset
    typedef struct packed {
        logic       flagOut;
        logic [1:0] cardClock;
        logic [2:0] syncRise;
        logic [1:0] syncFall;
        logic       clockMonitor;
        logic       toggleSelect;
        logic       floatOeN;
    } misc_pins_t;

endpackage : por_wake_pkg

// ---- verilog/por_reset_and_idle_wake_pin.sv ----
// Module: power-good, hardware reset, reset pin states and idle wake-up control
// Contract
// - Supply-ok stays low until bandgap 8 ms, analog 4 ms, core above 900 mV.
// - Hardware reset is AND of supply-ok and reset pin, both active low.
// - Hardware reset clears all logic except the RTC domain; here it clears only state and pin groups.
// - On reset release, enable clock generator, then start boot; here both rise in the same cycle.
// - Reset pin may be tied high; supply-ok alone then drives reset.
// - In reset: memory strobes, masks, flag high; strobe, card clocks low; others float.
// - In reset the clock monitor and one select pin keep toggling.
// - In reset sync select pins go 0 to 1, reserved pins 1 to 0.
// - In reset address lines go synchronously to 0, bank lines to 1.
// - Deep idle runs system clock from input clock or RTC clock by select.
// - Wake latency: 1 cycle deep/ref, 30.5 us deep/RTC, 3 cycles light.
// - External interrupts wake only from deep or light idle.
// - RTC interrupt wakes from deep and light idle.
// - Any unmasked interrupt leaves light idle.
// - Each peripheral interrupt has its own enable.
`timescale 1ns/10ps
`default_nettype none

module por_reset_and_idle_wake_pin #(
    parameter int unsigned BANDGAP_CYC = por_wake_pkg::BANDGAP_CYCLES,
    parameter int unsigned ANALOG_CYC  = por_wake_pkg::ANALOG_CYCLES,
    parameter int unsigned RTC_CYC     = por_wake_pkg::RTC_WAKE_CYCLES,
    parameter int unsigned PERIPH_N    = 8
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  resetPinN,
    input  wire logic                  bandgapActive,
    input  wire logic                  analogSupply,
    input  wire logic                  coreRegulatorAbove,
    input  wire logic                  wakePinN,
    input  wire logic [1:0]            externalIrqPinN,
    input  wire logic                  rtcIrq,
    input  wire logic [PERIPH_N-1:0]   periphIrq,
    input  wire logic [PERIPH_N-1:0]   periphIrqEnable,
    input  wire logic                  idleRequest,
    input  wire logic                  deepIdleSelect,
    input  wire logic                  clockSourceSelect,
    output logic                       supplyOkFlag,
    output logic                       hwResetN,
    output logic                       clockGenEnable,
    output logic                       bootStart,
    output logic                       systemClockGateOff,
    output logic                       clockFromRtc,
    output logic                       cpuActive,
    output por_wake_pkg::mem_pins_t    memPins,
    output por_wake_pkg::misc_pins_t   miscPins
);

    // ------------------------------------------------------------------
    // Input synchronisers (three flops, second and third agree)
    // ------------------------------------------------------------------
    localparam int unsigned SYNC_N = 7;
    logic [SYNC_N-1:0] rawIn;
    logic [SYNC_N-1:0] s1Reg;
    logic [SYNC_N-1:0] s2Reg;
    logic [SYNC_N-1:0] s3Reg;
    logic [SYNC_N-1:0] filtReg;
    logic [SYNC_N-1:0] filtNext;

    assign rawIn = {resetPinN, bandgapActive, analogSupply, coreRegulatorAbove,
                    wakePinN, externalIrqPinN};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            assign filtNext[gi] = (s2Reg[gi] == s3Reg[gi]) ? s3Reg[gi] : filtReg[gi];
        end
    endgenerate

    // Synchroniser chain; filter powers up with wake and interrupt pins high, reset pin and supplies low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1Reg   <= 7'h07;
            s2Reg   <= 7'h07;
            s3Reg   <= 7'h07;
            filtReg <= 7'h07;
        end else begin
            s1Reg   <= rawIn;
            s2Reg   <= s1Reg;
            s3Reg   <= s2Reg;
            filtReg <= filtNext;
        end
    end

    wire pinResetN  = filtReg[6];
    wire bandgapOk  = filtReg[5];
    wire analogOk   = filtReg[4];
    wire coreOk     = filtReg[3];
    wire wakeLow    = ~filtReg[2];
    wire extIrqLow  = ~(&filtReg[1:0]);

    // ------------------------------------------------------------------
    // Supply-ok qualification
    // ------------------------------------------------------------------
    logic [31:0] bgCountReg;
    logic [31:0] anCountReg;
    logic        supplyOkReg;

    wire bgDone = (bgCountReg >= BANDGAP_CYC);
    wire anDone = (anCountReg >= ANALOG_CYC);
    wire supplyOkNext = bgDone && anDone && coreOk;

    // Settle counters saturate once their time is reached
    wire [31:0] bgStep = bgDone ? bgCountReg : bgCountReg + 32'h1;
    wire [31:0] anStep = anDone ? anCountReg : anCountReg + 32'h1;

    // Settle counters restart whenever their supply drops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bgCountReg  <= 32'h00000000;
            anCountReg  <= 32'h00000000;
            supplyOkReg <= 1'b0;
        end else begin
            bgCountReg  <= bandgapOk ? bgStep : 32'h00000000;
            anCountReg  <= analogOk ? anStep : 32'h00000000;
            supplyOkReg <= supplyOkNext;
        end
    end

    // ------------------------------------------------------------------
    // Hardware reset: async assert, sync release
    // ------------------------------------------------------------------
    wire resetCombN = supplyOkReg & pinResetN;
    logic [1:0] relReg;
    logic       hwResetNReg;

    // Release passes two flops; a low on either source asserts at once
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            relReg <= 2'h0;
        end else if (!resetCombN) begin
            relReg <= 2'h0;
        end else begin
            relReg <= {relReg[0], 1'b1};
        end
    end

    wire inReset = ~relReg[1] | ~resetCombN;

    // ------------------------------------------------------------------
    // Power state machine and wake latency
    // ------------------------------------------------------------------
    por_wake_pkg::power_state_t stateReg;
    por_wake_pkg::power_state_t stateNext;
    logic [31:0] wakeCntReg;
    logic [31:0] wakeCntNext;
    logic        wakingReg;
    logic        wakingNext;
    logic        srcRtcReg;

    wire periphHit   = |(periphIrq & periphIrqEnable);
    wire deepWake    = wakeLow || extIrqLow || rtcIrq;
    wire lightWake   = extIrqLow || rtcIrq || periphHit;
    wire [31:0] deepLatency = srcRtcReg ? RTC_CYC : por_wake_pkg::REF_WAKE_CYCLES;
    wire wakeDone    = wakingReg && (wakeCntReg + 32'h1 >= deepLatency);
    wire lightDone   = wakingReg && (wakeCntReg + 32'h1 >= por_wake_pkg::LIGHT_WAKE_CYCLES);

    // Next state: run, enter idle on request, count latency after wake
    always_comb begin
        stateNext   = stateReg;
        wakeCntNext = wakingReg ? wakeCntReg + 32'h1 : 32'h00000000;
        wakingNext  = wakingReg;
        unique case (stateReg)
            por_wake_pkg::ST_RESET: begin
                stateNext = por_wake_pkg::ST_RUN;
            end
            por_wake_pkg::ST_RUN: begin
                if (idleRequest) begin
                    stateNext = deepIdleSelect ? por_wake_pkg::ST_DEEP : por_wake_pkg::ST_LIGHT;
                end
            end
            por_wake_pkg::ST_LIGHT: begin
                if (lightDone) begin
                    stateNext  = por_wake_pkg::ST_RUN;
                    wakingNext = 1'b0;
                end else if (lightWake) begin
                    wakingNext = 1'b1;
                end
            end
            por_wake_pkg::ST_DEEP: begin
                if (wakeDone) begin
                    stateNext  = por_wake_pkg::ST_RUN;
                    wakingNext = 1'b0;
                end else if (deepWake) begin
                    wakingNext = 1'b1;
                end
            end
        endcase
    end

    // State register; latch clock source on entry to deep idle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stateReg   <= por_wake_pkg::ST_RESET;
            wakeCntReg <= 32'h00000000;
            wakingReg  <= 1'b0;
            srcRtcReg  <= 1'b0;
        end else if (inReset) begin
            stateReg   <= por_wake_pkg::ST_RESET;
            wakeCntReg <= 32'h00000000;
            wakingReg  <= 1'b0;
            srcRtcReg  <= 1'b0;
        end else begin
            stateReg   <= stateNext;
            wakeCntReg <= wakeCntNext;
            wakingReg  <= wakingNext;
            if (stateReg == por_wake_pkg::ST_RUN && stateNext == por_wake_pkg::ST_DEEP) begin
                srcRtcReg <= ~clockSourceSelect;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs and reset pin states
    // ------------------------------------------------------------------
    logic toggleReg;

    // All outputs come from flops; pin groups take reset levels in reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            supplyOkFlag       <= 1'b0;
            hwResetNReg        <= 1'b0;
            clockGenEnable     <= 1'b0;
            bootStart          <= 1'b0;
            systemClockGateOff <= 1'b0;
            clockFromRtc       <= 1'b0;
            cpuActive          <= 1'b0;
            toggleReg          <= 1'b0;
            memPins            <= '{chipSelectN: 4'hF, outputEnableN: 1'b1, writeEnableN: 1'b1,
                                    byteMaskN: 2'h3, readWrite: 1'b0,
                                    address: por_wake_pkg::ADDR_RST, bankAddress: 2'h0};
            miscPins           <= '{flagOut: 1'b1, cardClock: 2'h0, syncRise: 3'h0,
                                    syncFall: 2'h3, clockMonitor: 1'b0, toggleSelect: 1'b0,
                                    floatOeN: 1'b1};
        end else begin
            supplyOkFlag       <= supplyOkReg;
            hwResetNReg        <= ~inReset;
            clockGenEnable     <= ~inReset && stateNext != por_wake_pkg::ST_DEEP;
            bootStart          <= ~inReset && stateReg == por_wake_pkg::ST_RESET;
            systemClockGateOff <= ~inReset && stateNext == por_wake_pkg::ST_DEEP;
            clockFromRtc       <= ~inReset && stateNext == por_wake_pkg::ST_DEEP && srcRtcReg;
            cpuActive          <= ~inReset && stateNext == por_wake_pkg::ST_RUN;
            toggleReg          <= ~toggleReg;
            if (inReset) begin
                memPins.chipSelectN   <= 4'hF;
                memPins.outputEnableN <= 1'b1;
                memPins.writeEnableN  <= 1'b1;
                memPins.byteMaskN     <= 2'h3;
                memPins.readWrite     <= 1'b0;
                memPins.address       <= por_wake_pkg::ADDR_RST;
                memPins.bankAddress   <= por_wake_pkg::BANK_RST;
                miscPins.flagOut      <= 1'b1;
                miscPins.cardClock    <= 2'h0;
                miscPins.syncRise     <= 3'h7;
                miscPins.syncFall     <= 2'h0;
                miscPins.floatOeN     <= 1'b1;
            end else begin
                miscPins.floatOeN     <= 1'b0;
            end
            miscPins.clockMonitor <= ~toggleReg;
            miscPins.toggleSelect <= ~toggleReg;
        end
    end

    assign hwResetN = hwResetNReg;

endmodule : por_reset_and_idle_wake_pin

`default_nettype wire

// ---- test/board_source.sv ----
// Board reset supervisor and wake/interrupt sources behind the block
`timescale 1ns/10ps
`default_nettype none
module board_source (
    input  wire logic       sys_clk,
    input  wire logic [3:0] req,
    output logic            resetPinN,
    output logic            wakePinN,
    output logic [1:0]      externalIrqPinN
);
    // ------------------------------------------------------------
    // Lines held low at least their minimum once requested
    // ------------------------------------------------------------
    localparam int MINC [4] = '{3, 1, 2, 2};
    int          cnt [4] = '{9, 9, 9, 9};
    logic [3:0]  low;
    // Stretch counters advance on the rising edge, clear of the bench's drive edge
    always @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (req[i]) cnt[i] <= 0;
            else if (cnt[i] < 9) cnt[i] <= cnt[i] + 1;
        end
    end
    // Pulled-up lines go high once released
    always_comb begin
        for (int i = 0; i < 4; i++) low[i] = req[i] || (cnt[i] < MINC[i]);
    end
    assign resetPinN       = ~low[0];
    assign wakePinN        = ~low[1];
    assign externalIrqPinN = ~low[3:2];
endmodule : board_source
`default_nettype wire

// ---- test/por_wake_checker.sv ----
// Checker: port assertions for the reset and idle wake-up block
`timescale 1ns/10ps
`default_nettype none
module por_wake_checker (
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire logic                     resetPinN,
    input wire logic                     coreRegulatorAbove,
    input wire logic                     rtcIrq,
    input wire logic                     supplyOkFlag,
    input wire logic                     hwResetN,
    input wire logic                     clockGenEnable,
    input wire logic                     bootStart,
    input wire logic                     systemClockGateOff,
    input wire logic                     clockFromRtc,
    input wire logic                     cpuActive,
    input wire por_wake_pkg::mem_pins_t  memPins,
    input wire por_wake_pkg::misc_pins_t miscPins
);
    // ------------------------------------------------------------
    // Reset pin states, boot start and wake relations
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_high_group: assert property (!hwResetN && $past(!hwResetN) |->
        memPins.chipSelectN == 4'hF && memPins.outputEnableN && memPins.writeEnableN
        && memPins.byteMaskN == 2'h3 && miscPins.flagOut) else $error("high group wrong");
    a_low_float: assert property (!hwResetN && $past(!hwResetN) |->
        !memPins.readWrite && miscPins.cardClock == 2'h0 && miscPins.floatOeN)
        else $error("low or float group wrong");
    a_sync_levels: assert property (!hwResetN && $past(!hwResetN) && !$past(rst) |->
        miscPins.syncRise == 3'h7 && miscPins.syncFall == 2'h0 && memPins.address == 21'h000000
        && memPins.bankAddress == 2'h3) else $error("sync pin levels wrong");
    a_clock_toggle: assert property (!hwResetN && !supplyOkFlag && $past(!supplyOkFlag)
        && !$past(rst) |-> miscPins.clockMonitor != $past(miscPins.clockMonitor)
        && miscPins.toggleSelect != $past(miscPins.toggleSelect)) else $error("no toggle");
    a_boot_pulse: assert property ($rose(hwResetN) |->
        bootStart && clockGenEnable ##1 !bootStart) else $error("boot pulse wrong");
    a_boot_cause: assert property (bootStart |-> $rose(hwResetN)) else $error("stray boot");
    a_supply_and: assert property (hwResetN |-> supplyOkFlag)
        else $error("reset without supply");
    a_pin_reset: assert property (!resetPinN [*3] |-> ##[0:8] !hwResetN)
        else $error("pin reset missed");
    a_supply_drop: assert property ($fell(coreRegulatorAbove) |->
        ##[0:8] (!hwResetN && !supplyOkFlag)) else $error("supply drop missed");
    a_gate_off: assert property (systemClockGateOff |-> !clockGenEnable && !cpuActive)
        else $error("clock gate state wrong");
    a_rtc_wake: assert property ($rose(rtcIrq) && hwResetN && $past(hwResetN, 3)
        && !cpuActive && !systemClockGateOff |-> ##[1:8] cpuActive) else $error("rtc light wake late");
    c_boot: cover property (bootStart);
    c_deep_rtc: cover property (systemClockGateOff && clockFromRtc);
    c_deep_wake: cover property ($rose(cpuActive) && $past(systemClockGateOff));
endmodule : por_wake_checker
bind por_reset_and_idle_wake_pin por_wake_checker u_chk (.sys_clk(sys_clk), .rst(rst),
    .resetPinN(resetPinN), .coreRegulatorAbove(coreRegulatorAbove), .rtcIrq(rtcIrq),
    .supplyOkFlag(supplyOkFlag), .hwResetN(hwResetN), .clockGenEnable(clockGenEnable),
    .bootStart(bootStart), .systemClockGateOff(systemClockGateOff),
    .clockFromRtc(clockFromRtc), .cpuActive(cpuActive), .memPins(memPins), .miscPins(miscPins));
`default_nettype wire

// ---- test/tb.sv ----
// Testbench: power-up, idle wake table, pin reset, supply drop, async reset
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {logic [1:0] mode; logic [2:0] src; logic woke;} row_t;
    logic sys_clk, rst, bandgapActive, analogSupply, coreRegulatorAbove, rtcIrq;
    logic idleRequest, deepIdleSelect, clockSourceSelect;
    logic [7:0] periphIrq, periphIrqEnable;
    logic [3:0] req;
    wire logic resetPinN, wakePinN;
    wire logic [1:0] externalIrqPinN;
    logic supplyOkFlag, hwResetN, clockGenEnable, bootStart, systemClockGateOff;
    logic clockFromRtc, cpuActive;
    por_wake_pkg::mem_pins_t  memPins;
    por_wake_pkg::misc_pins_t miscPins;
    int fail_count = 0, checks_done = 0, cycles = 0, n, lat;
    row_t rows [8];
    // ------------------------------------------------------------
    // Clock, partner, design, timeout
    // ------------------------------------------------------------
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    board_source board (.sys_clk(sys_clk), .req(req), .resetPinN(resetPinN),
        .wakePinN(wakePinN), .externalIrqPinN(externalIrqPinN));
    por_reset_and_idle_wake_pin #(.BANDGAP_CYC(20), .ANALOG_CYC(10), .RTC_CYC(5), .PERIPH_N(8)) DUT (
        .sys_clk(sys_clk), .rst(rst), .resetPinN(resetPinN), .bandgapActive(bandgapActive),
        .analogSupply(analogSupply), .coreRegulatorAbove(coreRegulatorAbove),
        .wakePinN(wakePinN), .externalIrqPinN(externalIrqPinN), .rtcIrq(rtcIrq),
        .periphIrq(periphIrq), .periphIrqEnable(periphIrqEnable), .idleRequest(idleRequest),
        .deepIdleSelect(deepIdleSelect), .clockSourceSelect(clockSourceSelect),
        .supplyOkFlag(supplyOkFlag), .hwResetN(hwResetN), .clockGenEnable(clockGenEnable),
        .bootStart(bootStart), .systemClockGateOff(systemClockGateOff),
        .clockFromRtc(clockFromRtc), .cpuActive(cpuActive), .memPins(memPins),
        .miscPins(miscPins));
    // Cuts a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc
    task automatic wait_active(output int c);
        c = 0;
        while (cpuActive !== 1'b1 && c < 60) begin cyc(1); c++; end
    endtask : wait_active
    task automatic wait_rst(input logic v, output int c);
        c = 0;
        while (hwResetN !== v && c < 300) begin cyc(1); c++; end
    endtask : wait_rst
    task automatic drive(input logic [2:0] s, input logic on);
        case (s)
            3'h0: req[1] = on;
            3'h1: req[2] = on;
            3'h2: rtcIrq = on;
            3'h3: periphIrq[0] = on;
            3'h4: periphIrq[2] = on;
            default: req[3] = on;
        endcase
    endtask : drive
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1; bandgapActive = 1; analogSupply = 1; coreRegulatorAbove = 1; rtcIrq = 0;
        idleRequest = 0; deepIdleSelect = 0; clockSourceSelect = 0; req = 4'h0;
        periphIrq = 8'h00; periphIrqEnable = 8'hFB;
        rows = '{'{2'h1, 3'h1, 1'b1}, '{2'h1, 3'h2, 1'b1}, '{2'h1, 3'h3, 1'b1},
            '{2'h1, 3'h4, 1'b0}, '{2'h1, 3'h0, 1'b0}, '{2'h2, 3'h0, 1'b1},
            '{2'h3, 3'h5, 1'b1}, '{2'h2, 3'h2, 1'b1}};
        cyc(20);
        rst = 0;
        wait_rst(1'b1, n);
        check(n >= 20, 1);
        wait_active(n);
        check(cpuActive, 1);
        $display("power-up test done");
        foreach (rows[i]) begin
            deepIdleSelect = rows[i].mode != 2'h1;
            clockSourceSelect = rows[i].mode == 2'h2;
            idleRequest = 1;
            cyc(1);
            idleRequest = 0;
            cyc(3);
            check(systemClockGateOff, rows[i].mode != 2'h1);
            check(clockFromRtc, rows[i].mode == 2'h3);
            drive(rows[i].src, 1'b1);
            wait_active(n);
            check(cpuActive, rows[i].woke);
            // Latency in cycles; pins add up to five cycles of sync and capture
            lat = rows[i].mode == 2'h1 ? 3 : rows[i].mode == 2'h2 ? 1 : 5;
            if (rows[i].woke) check(n >= lat, 1);
            if (rows[i].woke) check(n <= lat + 5, 1);
            drive(rows[i].src, 1'b0);
            if (!rows[i].woke) begin drive(3'h2, 1'b1); wait_active(n); drive(3'h2, 1'b0); end
            check(systemClockGateOff, 0);
            cyc(8);
            $display("wake test %0d done", i);
        end
        req[0] = 1;
        cyc(1);
        req[0] = 0;
        wait_rst(1'b0, n);
        check(hwResetN, 0);
        cyc(2);
        check(memPins.chipSelectN, 4'hF);
        check(memPins.bankAddress, por_wake_pkg::BANK_RST);
        check(miscPins.syncRise, 3'h7);
        wait_rst(1'b1, n);
        check(supplyOkFlag, 1);
        wait_active(n);
        $display("pin reset test done");
        coreRegulatorAbove = 0;
        cyc(12);
        check(supplyOkFlag, 0);
        check(hwResetN, 0);
        coreRegulatorAbove = 1;
        wait_rst(1'b1, n);
        check(hwResetN, 1);
        $display("supply drop test done");
        rst = 1;
        #1 check(hwResetN, 0);
        cyc(3);
        rst = 0;
        wait_rst(1'b1, n);
        check(n >= 20, 1);
        $display("async reset test done");
        close_out();
    end
endmodule : tb
`default_nettype wire
